// File: rtl/alufp_core.sv
/*
 * ALU flag datapath and port read-modify-write path of the core.
 * Assumes an instruction sequencer issues one request per req_valid pulse
 * and waits for done before the next; port pins are asynchronous.
 */
// How it works
// - rmw to port reads the latch
// - plain port input reads the pin
// - bit writes rewrite whole latch byte
// - logic, jbc, cpl, inc, dec, djnz read latch
// - add carry from bit 7
// - wrap flag is c6 xor c7
// - nibble carry from bit 3
// - addc sums acc, source, carry
// - subb takes source and borrow
// - subb carry is bit 7 borrow
// - subb wrap is b6 xor b7
// - subb nibble flag is bit 3 borrow
// - mul low to acc, high to b
// - mul clears carry, wrap if >255
// - div quotient to acc, remainder b
// - div clears carry, wrap when b zero
// - da adds 06 on low fixup
// - da adds 60 on carry or step one
// - da carry when result above 99
// - rrc rotates right through carry
// - rlc rotates left through carry
`timescale 1ns/1ps
`include "alufp_consts.svh"

module alufp_core #(
    parameter int NPORTS = 4
) (
    input  wire logic                    core_clk_i,   // core clock, 50 MHz
    input  wire logic                    reset_i,      // async reset, high
    input  wire logic                    req_valid_i,  // request strobe
    input  wire alufp_pkg::alufp_req_t   req_i,        // request fields
    input  wire logic [NPORTS*8-1:0]     port_pin_i,   // port pin levels
    output alufp_pkg::alufp_flags_t      flags_o,      // program status flags
    output logic [7:0]                   acc_o,        // accumulator
    output logic [7:0]                   b_o,          // b register
    output logic [NPORTS*8-1:0]          port_latch_o, // port output latches
    output logic [7:0]                   rd_data_o,    // pin read / rmw source
    output logic                         bit_o,        // tested/read bit
    output logic                         done_o        // request done pulse
);

    // ==========================================================
    // pin synchroniser
    logic [NPORTS*8-1:0] pin_meta_q;
    logic [NPORTS*8-1:0] pin_sync_q;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= port_pin_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    // ==========================================================
    // helpers
    function automatic logic [7:0] sel_byte(input logic [NPORTS*8-1:0] v,
                                            input logic [1:0] idx);
        sel_byte = v[idx*8 +: 8];
    endfunction

    function automatic logic is_port_rmw(input alufp_pkg::alufp_op_t op);
        is_port_rmw = op inside {alufp_pkg::ALUFP_OP_PANL, alufp_pkg::ALUFP_OP_PORL,
                                 alufp_pkg::ALUFP_OP_PXRL, alufp_pkg::ALUFP_OP_PINC,
                                 alufp_pkg::ALUFP_OP_PDEC, alufp_pkg::ALUFP_OP_PDJNZ,
                                 alufp_pkg::ALUFP_OP_PCPL, alufp_pkg::ALUFP_OP_PJBC,
                                 alufp_pkg::ALUFP_OP_PMOVC, alufp_pkg::ALUFP_OP_PCLRB,
                                 alufp_pkg::ALUFP_OP_PSETB};
    endfunction

    // ==========================================================
    // arithmetic
    alufp_pkg::alufp_op_t op;
    logic [7:0]  src;
    logic [7:0]  latch_byte;
    logic [7:0]  pin_byte;
    logic        cin;
    logic [4:0]  lo_sum;
    logic [3:0]  mid_sum;
    logic [1:0]  top_sum;
    logic [4:0]  lo_dif;
    logic [3:0]  mid_dif;
    logic [1:0]  top_dif;
    logic [15:0] product;
    logic        da_lo;
    logic        da_hi;
    logic [8:0]  da_step1;
    logic [8:0]  da_res;

    assign op         = req_i.op;
    assign src        = req_i.src;
    assign latch_byte = sel_byte(port_latch_o, req_i.port_sel);
    assign pin_byte   = sel_byte(pin_sync_q, req_i.port_sel);
    assign cin        = (op == alufp_pkg::ALUFP_OP_ADD) ? 1'b0 : flags_o.carry;

    // split so carries out of bits 3, 6 and 7 are visible
    assign lo_sum  = {1'b0, acc_o[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
    assign mid_sum = {1'b0, acc_o[6:4]} + {1'b0, src[6:4]} + {3'h0, lo_sum[4]};
    assign top_sum = {1'b0, acc_o[7]} + {1'b0, src[7]} + {1'b0, mid_sum[3]};
    assign lo_dif  = {1'b0, acc_o[3:0]} - {1'b0, src[3:0]} - {4'h0, flags_o.carry};
    assign mid_dif = {1'b0, acc_o[6:4]} - {1'b0, src[6:4]} - {3'h0, lo_dif[4]};
    assign top_dif = {1'b0, acc_o[7]} - {1'b0, src[7]} - {1'b0, mid_dif[3]};
    assign product = acc_o * b_o;

    assign da_lo    = flags_o.nibble_carry_flag || (acc_o[3:0] > `ALUFP_BCD_LO_MAX);
    assign da_step1 = {1'b0, acc_o} + (da_lo ? {1'b0, `ALUFP_BCD_LO_ADJ} : 9'h000);
    assign da_hi    = flags_o.carry || da_lo;
    // ninth bit kept so an overflowing adjust still counts as above 99
    assign da_res   = da_step1 + (da_hi ? {1'b0, `ALUFP_BCD_HI_ADJ} : 9'h000);

    // ==========================================================
    // divider
    logic       div_start;
    logic       div_done;
    logic [7:0] div_q;
    logic [7:0] div_r;
    logic       div_busy_q;

    assign div_start = req_valid_i && op == alufp_pkg::ALUFP_OP_DIV && b_o != 8'h00;

    alufp_divider #(.W(8)) u_div (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .start_i    (div_start),
        .dividend_i (acc_o),
        .divisor_i  (b_o),
        .done_o     (div_done),
        .quot_o     (div_q),
        .rem_o      (div_r)
    );

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_busy_q <= 1'b0;
        end else if (div_start) begin
            div_busy_q <= 1'b1;
        end else if (div_done) begin
            div_busy_q <= 1'b0;
        end
    end

    // ==========================================================
    // accumulator, b and flags
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_o   <= `ALUFP_RST_BYTE;
            b_o     <= `ALUFP_RST_BYTE;
            flags_o <= '0;
        end else if (div_done && div_busy_q) begin
            acc_o <= div_q;
            b_o   <= div_r;
        end else if (req_valid_i) begin
            unique case (op)
                alufp_pkg::ALUFP_OP_ADD, alufp_pkg::ALUFP_OP_ADDC: begin
                    acc_o <= {top_sum[0], mid_sum[2:0], lo_sum[3:0]};
                    flags_o.carry <= top_sum[1];
                    flags_o.signed_wrap_flag <= top_sum[1] ^ mid_sum[3];
                    flags_o.nibble_carry_flag <= lo_sum[4];
                end
                alufp_pkg::ALUFP_OP_SUBB: begin
                    acc_o <= {top_dif[0], mid_dif[2:0], lo_dif[3:0]};
                    flags_o.carry <= top_dif[1];
                    flags_o.signed_wrap_flag <= top_dif[1] ^ mid_dif[3];
                    flags_o.nibble_carry_flag <= lo_dif[4];
                end
                alufp_pkg::ALUFP_OP_MUL: begin
                    acc_o <= product[7:0];
                    b_o   <= product[15:8];
                    flags_o.carry <= 1'b0;
                    flags_o.signed_wrap_flag <= product > `ALUFP_BYTE_MAX;
                end
                alufp_pkg::ALUFP_OP_DIV: begin
                    // div flags; zero divisor leaves acc and b as they were
                    flags_o.carry <= 1'b0;
                    flags_o.signed_wrap_flag <= (b_o == 8'h00);
                end
                alufp_pkg::ALUFP_OP_DA: begin
                    acc_o <= da_res[7:0];
                    flags_o.carry <= da_res > `ALUFP_BCD_MAX;
                end
                alufp_pkg::ALUFP_OP_RRC: begin
                    acc_o <= {flags_o.carry, acc_o[7:1]};
                    flags_o.carry <= acc_o[0];
                end
                alufp_pkg::ALUFP_OP_RLC: begin
                    acc_o <= {acc_o[6:0], flags_o.carry};
                    flags_o.carry <= acc_o[7];
                end
                alufp_pkg::ALUFP_OP_MOVB: begin
                    b_o <= src;
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // port latches and read-back
    logic [7:0] rmw_new;
    logic [7:0] bit_mask;

    assign bit_mask = 8'h01 << req_i.bit_sel;

    always_comb begin
        rmw_new = latch_byte;
        unique case (op)
            alufp_pkg::ALUFP_OP_PANL:  rmw_new = latch_byte & acc_o;
            alufp_pkg::ALUFP_OP_PORL:  rmw_new = latch_byte | acc_o;
            alufp_pkg::ALUFP_OP_PXRL:  rmw_new = latch_byte ^ acc_o;
            alufp_pkg::ALUFP_OP_PINC:  rmw_new = latch_byte + 8'h01;
            alufp_pkg::ALUFP_OP_PDEC,
            alufp_pkg::ALUFP_OP_PDJNZ: rmw_new = latch_byte - 8'h01;
            alufp_pkg::ALUFP_OP_PCPL:  rmw_new = latch_byte ^ bit_mask;
            alufp_pkg::ALUFP_OP_PJBC,
            alufp_pkg::ALUFP_OP_PCLRB: rmw_new = latch_byte & ~bit_mask;
            alufp_pkg::ALUFP_OP_PSETB: rmw_new = latch_byte | bit_mask;
            alufp_pkg::ALUFP_OP_PMOVC:
                rmw_new = flags_o.carry ? (latch_byte | bit_mask) : (latch_byte & ~bit_mask);
            default:                   rmw_new = latch_byte;
        endcase
    end

    genvar gp;
    generate
        for (gp = 0; gp < NPORTS; gp++) begin : g_port
            always_ff @(posedge core_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    port_latch_o[gp*8 +: 8] <= `ALUFP_LATCH_RST;
                end else if (req_valid_i && is_port_rmw(op) && req_i.port_sel == gp) begin
                    port_latch_o[gp*8 +: 8] <= rmw_new;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_data_o <= `ALUFP_RST_BYTE;
            bit_o     <= 1'b0;
        end else if (req_valid_i) begin
            if (op inside {alufp_pkg::ALUFP_OP_PREAD, alufp_pkg::ALUFP_OP_PBITRD}) begin
                rd_data_o <= pin_byte;
                bit_o     <= pin_byte[req_i.bit_sel];
            end else if (is_port_rmw(op)) begin
                // modify path reports the latch value
                rd_data_o <= latch_byte;
                bit_o     <= latch_byte[req_i.bit_sel];
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= (req_valid_i && !div_start) || (div_done && div_busy_q);
        end
    end

    // ==========================================================
    // checks
    a_add_carry: assert property (@(posedge core_clk_i) disable iff (reset_i)
        req_valid_i && op == alufp_pkg::ALUFP_OP_ADD
        |=> flags_o.carry == ({1'b0, $past(acc_o)} + {1'b0, $past(src)} > 9'h0FF))
        else $error("add carry wrong");
    a_add_wrap: assert property (@(posedge core_clk_i) disable iff (reset_i)
        req_valid_i && op == alufp_pkg::ALUFP_OP_ADD && acc_o[7] == src[7]
        |=> flags_o.signed_wrap_flag == (acc_o[7] != $past(acc_o[7])))
        else $error("add wrap flag wrong");
    a_add_nibble: assert property (@(posedge core_clk_i) disable iff (reset_i)
        req_valid_i && op == alufp_pkg::ALUFP_OP_ADD
        |=> flags_o.nibble_carry_flag == ($past(acc_o[3:0]) + $past(src[3:0]) > 5'h0F))
        else $error("nibble carry wrong");
    a_subb_value: assert property (@(posedge core_clk_i) disable iff (reset_i)
        req_valid_i && op == alufp_pkg::ALUFP_OP_SUBB
        |=> acc_o == 8'($past(acc_o) - $past(src) - {7'h00, $past(flags_o.carry)}))
        else $error("subb result wrong");
    a_mul_flags: assert property (@(posedge core_clk_i) disable iff (reset_i)
        req_valid_i && op == alufp_pkg::ALUFP_OP_MUL
        |=> !flags_o.carry && flags_o.signed_wrap_flag == (b_o != 8'h00))
        else $error("mul flags wrong");
    a_mul_value: assert property (@(posedge core_clk_i) disable iff (reset_i)
        req_valid_i && op == alufp_pkg::ALUFP_OP_MUL
        |=> {b_o, acc_o} == $past(acc_o) * $past(b_o))
        else $error("mul product wrong");
    a_da_carry: assert property (@(posedge core_clk_i) disable iff (reset_i)
        req_valid_i && op == alufp_pkg::ALUFP_OP_DA
        |=> flags_o.carry || {1'b0, acc_o} <= `ALUFP_BCD_MAX)
        else $error("da carry wrong");
    a_div_zero: assert property (@(posedge core_clk_i) disable iff (reset_i)
        req_valid_i && op == alufp_pkg::ALUFP_OP_DIV && b_o == 8'h00
        |=> flags_o.signed_wrap_flag && !flags_o.carry && done_o)
        else $error("div by zero flags wrong");
    a_div_result: assert property (@(posedge core_clk_i) disable iff (reset_i)
        div_start ##10 1'b1 |-> done_o && acc_o == $past(acc_o, 10) / $past(b_o, 10)
        && b_o == $past(acc_o, 10) % $past(b_o, 10))
        else $error("div quotient wrong");
    a_rrc_carry: assert property (@(posedge core_clk_i) disable iff (reset_i)
        req_valid_i && op == alufp_pkg::ALUFP_OP_RRC
        |=> flags_o.carry == $past(acc_o[0]) && acc_o[7] == $past(flags_o.carry))
        else $error("rrc wrong");
    a_rlc_carry: assert property (@(posedge core_clk_i) disable iff (reset_i)
        req_valid_i && op == alufp_pkg::ALUFP_OP_RLC
        |=> flags_o.carry == $past(acc_o[7]) && acc_o[0] == $past(flags_o.carry))
        else $error("rlc wrong");
    a_setb_latch: assert property (@(posedge core_clk_i) disable iff (reset_i)
        req_valid_i && op == alufp_pkg::ALUFP_OP_PSETB
        |=> rd_data_o == ($past(latch_byte)))
        else $error("setb not from latch");

    c_add:  cover property (@(posedge core_clk_i) req_valid_i && op == alufp_pkg::ALUFP_OP_ADDC);
    c_div:  cover property (@(posedge core_clk_i) div_done);
    c_da:   cover property (@(posedge core_clk_i) req_valid_i && op == alufp_pkg::ALUFP_OP_DA && da_hi);
    c_rmw:  cover property (@(posedge core_clk_i) req_valid_i && op == alufp_pkg::ALUFP_OP_PJBC);

endmodule

// File: pkg/alufp_consts.svh
/*
 * Constants for the core ALU flag and port read-modify-write datapath.
 * Assumes inclusion by bare name from design files.
 */
`ifndef ALUFP_CONSTS_SVH
`define ALUFP_CONSTS_SVH

`define ALUFP_BCD_LO_ADJ   8'h06
`define ALUFP_BCD_HI_ADJ   8'h60
`define ALUFP_BCD_LO_MAX   4'h9
`define ALUFP_BCD_MAX      9'h099
`define ALUFP_BYTE_MAX     16'h00FF
`define ALUFP_RST_BYTE     8'h00
`define ALUFP_LATCH_RST    8'hFF
`define ALUFP_DIV_STEPS    4'h8

`endif

// File: pkg/alufp_pkg.sv
/*
 * Types for the core ALU flag and port read-modify-write datapath.
 * Assumes nothing of its surroundings.
 */
package alufp_pkg;

    // ==========================================================
    // operation codes
    typedef enum logic [4:0] {
        ALUFP_OP_ADD,
        ALUFP_OP_ADDC,
        ALUFP_OP_SUBB,
        ALUFP_OP_MUL,
        ALUFP_OP_DIV,
        ALUFP_OP_DA,
        ALUFP_OP_RRC,
        ALUFP_OP_RLC,
        // loads b from src, so mul and div can be given an operand
        ALUFP_OP_MOVB,
        ALUFP_OP_PANL,
        ALUFP_OP_PORL,
        ALUFP_OP_PXRL,
        ALUFP_OP_PINC,
        ALUFP_OP_PDEC,
        ALUFP_OP_PDJNZ,
        ALUFP_OP_PCPL,
        ALUFP_OP_PJBC,
        ALUFP_OP_PMOVC,
        ALUFP_OP_PCLRB,
        ALUFP_OP_PSETB,
        ALUFP_OP_PREAD,
        ALUFP_OP_PBITRD
    } alufp_op_t;

    // ==========================================================
    // program status flags
    typedef struct packed {
        logic carry;
        logic nibble_carry_flag;
        logic signed_wrap_flag;
    } alufp_flags_t;

    // ==========================================================
    // one request
    typedef struct packed {
        alufp_op_t  op;
        logic [7:0] src;
        logic [2:0] bit_sel;
        logic [1:0] port_sel;
    } alufp_req_t;

endpackage

// File: rtl/alufp_divider.sv
/*
 * Unsigned 8-bit restoring divider, one quotient bit per cycle.
 * Assumes start is pulsed only while idle; divisor zero handled by caller.
 */
`timescale 1ns/1ps
`include "alufp_consts.svh"

module alufp_divider #(
    parameter int W = 8
) (
    input  wire logic         core_clk_i, // core clock
    input  wire logic         reset_i,    // async reset, high
    input  wire logic         start_i,    // start pulse
    input  wire logic [W-1:0] dividend_i, // accumulator value
    input  wire logic [W-1:0] divisor_i,  // b register value
    output logic              done_o,     // one-cycle done pulse
    output logic [W-1:0]      quot_o,     // quotient
    output logic [W-1:0]      rem_o       // remainder
);

    logic [3:0]   cnt_q;
    logic         busy_q;
    logic [W:0]   trial;

    assign trial = {rem_o, quot_o[W-1]} - {1'b0, divisor_i};

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            busy_q <= 1'b0;
            cnt_q  <= 4'h0;
            done_o <= 1'b0;
            quot_o <= '0;
            rem_o  <= '0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_q) begin
                busy_q <= 1'b1;
                cnt_q  <= `ALUFP_DIV_STEPS;
                quot_o <= dividend_i;
                rem_o  <= '0;
            end else if (busy_q) begin
                // restoring step: shift, subtract if it fits
                if (trial[W]) begin
                    rem_o <= {rem_o[W-2:0], quot_o[W-1]};
                    quot_o <= {quot_o[W-2:0], 1'b0};
                end else begin
                    rem_o <= trial[W-1:0];
                    quot_o <= {quot_o[W-2:0], 1'b1};
                end
                cnt_q <= cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    busy_q <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end

endmodule

// File: test/alufp_core_test.sv
/*
 * Self-checking testbench for the core ALU flag and port rmw datapath.
 * Assumes the package and constants header are compiled first; the bench
 * drives every port itself and keeps its own model of acc, b, flags, latches.
 */
`timescale 1ns/1ps

module alufp_core_test;

    // ==========================================================
    // stimulus and observed signals
    logic                    core_clk_i;
    logic                    reset_i;
    logic                    req_valid_i;
    alufp_pkg::alufp_req_t   req_i;
    logic [31:0]             port_pin_i;
    alufp_pkg::alufp_flags_t flags_o;
    logic [7:0]              acc_o;
    logic [7:0]              b_o;
    logic [31:0]             port_latch_o;
    logic [7:0]              rd_data_o;
    logic                    bit_o;
    logic                    done_o;
    int                      n_mismatch;
    int                      comparisons;
    // bench model state
    logic [7:0]              m_acc;
    logic [7:0]              m_b;
    logic                    m_c;
    logic                    m_ac;
    logic                    m_ov;
    logic [31:0]             m_lat;

    alufp_core #(.NPORTS(4)) i_dut (
        .core_clk_i   (core_clk_i),
        .reset_i      (reset_i),
        .req_valid_i  (req_valid_i),
        .req_i        (req_i),
        .port_pin_i   (port_pin_i),
        .flags_o      (flags_o),
        .acc_o        (acc_o),
        .b_o          (b_o),
        .port_latch_o (port_latch_o),
        .rd_data_o    (rd_data_o),
        .bit_o        (bit_o),
        .done_o       (done_o)
    );

    always #10 core_clk_i = ~core_clk_i;

    // ==========================================================
    // shared tasks
    task automatic complete_run();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // model first, then one request, then compare everything it may touch
    task automatic do_op(input alufp_pkg::alufp_op_t op, input logic [7:0] s,
                         input logic [2:0] bs, input logic [1:0] ps);
        int         a;
        int         ci;
        int         t;
        int         n;
        logic [7:0] lb;
        logic [7:0] eb;
        logic [7:0] erd;
        a = m_acc;
        ci = m_c;
        t = 0;
        lb = m_lat[ps*8 +: 8];
        eb = lb;
        erd = lb;
        case (op)
            alufp_pkg::ALUFP_OP_ADD, alufp_pkg::ALUFP_OP_ADDC: begin
                if (op == alufp_pkg::ALUFP_OP_ADD) ci = 0;
                t = a + s + ci;
                m_ac = ((a % 16 + s % 16 + ci) > 15);
                m_ov = ((a % 128 + s % 128 + ci) > 127) ^ (t > 255);
                m_c = (t > 255);
                m_acc = t[7:0];
            end
            alufp_pkg::ALUFP_OP_SUBB: begin
                t = a - s - ci;
                m_ac = (a % 16 < s % 16 + ci);
                m_ov = (a % 128 < s % 128 + ci) ^ (a < s + ci);
                m_c = (a < s + ci);
                m_acc = t[7:0];
            end
            alufp_pkg::ALUFP_OP_MUL: begin
                t = a * m_b;
                m_acc = t[7:0];
                m_b = t[15:8];
                m_c = 1'b0;
                m_ov = (t > 255);
            end
            alufp_pkg::ALUFP_OP_DIV: begin
                m_c = 1'b0;
                m_ov = (m_b == 8'h00);
                // zero divisor leaves acc and b alone, the check expects them unchanged
                if (!m_ov) begin
                    m_acc = 8'(a / m_b);
                    m_b = 8'(a % m_b);
                end
            end
            alufp_pkg::ALUFP_OP_DA: begin
                t = a;
                if (m_ac || (a % 16) > 9) begin
                    t = t + 6;
                    ci = 1;
                end
                if (ci == 1) t = t + 96;
                m_c = (t > 153);
                m_acc = t[7:0];
            end
            alufp_pkg::ALUFP_OP_RRC: {m_acc, m_c} = {m_c, m_acc};
            alufp_pkg::ALUFP_OP_RLC: {m_c, m_acc} = {m_acc, m_c};
            alufp_pkg::ALUFP_OP_MOVB: m_b = s;
            alufp_pkg::ALUFP_OP_PANL: eb = lb & m_acc;
            alufp_pkg::ALUFP_OP_PORL: eb = lb | m_acc;
            alufp_pkg::ALUFP_OP_PXRL: eb = lb ^ m_acc;
            alufp_pkg::ALUFP_OP_PINC: eb = lb + 8'h01;
            alufp_pkg::ALUFP_OP_PDEC, alufp_pkg::ALUFP_OP_PDJNZ: eb = lb - 8'h01;
            alufp_pkg::ALUFP_OP_PCPL: eb[bs] = ~lb[bs];
            alufp_pkg::ALUFP_OP_PJBC, alufp_pkg::ALUFP_OP_PCLRB: eb[bs] = 1'b0;
            alufp_pkg::ALUFP_OP_PMOVC: eb[bs] = m_c;
            alufp_pkg::ALUFP_OP_PSETB: eb[bs] = 1'b1;
            default: erd = port_pin_i[ps*8 +: 8];
        endcase
        m_lat[ps*8 +: 8] = eb;
        @(negedge core_clk_i);
        req_i = '{op: op, src: s, bit_sel: bs, port_sel: ps};
        req_valid_i = 1'b1;
        @(negedge core_clk_i);
        req_valid_i = 1'b0;
        for (n = 0; n < 20 && done_o !== 1'b1; n++) @(negedge core_clk_i);
        if (n == 20) begin
            n_mismatch++;
            complete_run();
        end
        chk(32'({acc_o, b_o, flags_o}), 32'({m_acc, m_b, m_c, m_ac, m_ov}));
        chk(port_latch_o, m_lat);
        if (op >= alufp_pkg::ALUFP_OP_PANL) chk(32'({rd_data_o, bit_o}), 32'({erd, erd[bs]}));
    endtask

    // ==========================================================
    // scenarios
    task automatic check_reset();
        chk(32'({acc_o, b_o, flags_o, done_o}), 32'h0);
        chk(port_latch_o, 32'hFFFFFFFF);
    endtask

    // signed wrap and nibble carry edges, carry chained through addc
    task automatic add_cases();
        do_op(alufp_pkg::ALUFP_OP_ADD, 8'h7F, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_ADD, 8'h01, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_ADD, 8'h80, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_ADDC, 8'h0F, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_ADDC, 8'hFF, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_ADDC, 8'h6F, 3'h0, 2'h0);
    endtask

    // borrow chain, with a borrow-in carried into two of the five subtracts
    task automatic subb_cases();
        do_op(alufp_pkg::ALUFP_OP_SUBB, 8'h80, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_SUBB, 8'h01, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_SUBB, 8'h7F, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_SUBB, 8'hFF, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_SUBB, 8'h00, 3'h0, 2'h0);
    endtask

    // zero divisor first, then real divides and products with and without wrap
    task automatic muldiv_cases();
        do_op(alufp_pkg::ALUFP_OP_ADD, 8'hF0, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_ADD, 8'hF0, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_MOVB, 8'h00, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_DIV, 8'h00, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_MOVB, 8'h07, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_DIV, 8'h00, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_RLC, 8'h00, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_MUL, 8'h00, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_MOVB, 8'h10, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_MUL, 8'h00, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_DIV, 8'h00, 3'h0, 2'h0);
    endtask

    task automatic da_cases();
        do_op(alufp_pkg::ALUFP_OP_ADD, 8'h09, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_ADD, 8'h09, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_DA, 8'h00, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_ADD, 8'h22, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_DA, 8'h00, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_SUBB, 8'hEB, 3'h0, 2'h0);
        do_op(alufp_pkg::ALUFP_OP_DA, 8'h00, 3'h0, 2'h0);
    endtask

    task automatic rotate_cases();
        do_op(alufp_pkg::ALUFP_OP_ADD, 8'h81, 3'h0, 2'h0);
        repeat (3) do_op(alufp_pkg::ALUFP_OP_RRC, 8'h00, 3'h0, 2'h0);
        repeat (3) do_op(alufp_pkg::ALUFP_OP_RLC, 8'h00, 3'h0, 2'h0);
    endtask

    // pins differ from latches, so a pin read in a rmw op shows up
    task automatic port_cases();
        int k;
        int j;
        port_pin_i = 32'h3C5A96E1;
        repeat (4) @(negedge core_clk_i);
        for (j = 0; j < 2; j++) begin
            for (k = alufp_pkg::ALUFP_OP_PANL; k <= alufp_pkg::ALUFP_OP_PSETB; k++) begin
                do_op(alufp_pkg::alufp_op_t'(k), 8'h00, 3'(k + j), 2'(k + j));
            end
            do_op(alufp_pkg::ALUFP_OP_RRC, 8'h00, 3'h0, 2'h0);
        end
        for (k = 0; k < 4; k++) begin
            do_op(alufp_pkg::ALUFP_OP_PREAD, 8'h00, 3'h0, 2'(k));
            do_op(alufp_pkg::ALUFP_OP_PBITRD, 8'h00, 3'(k * 3), 2'(k));
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        core_clk_i = 1'b0;
        reset_i = 1'b1;
        req_valid_i = 1'b0;
        req_i = '0;
        port_pin_i = 32'h00000000;
        n_mismatch = 0;
        comparisons = 0;
        m_acc = 8'h00;
        m_b = 8'h00;
        m_c = 1'b0;
        m_ac = 1'b0;
        m_ov = 1'b0;
        m_lat = 32'hFFFFFFFF;
        repeat (10) @(negedge core_clk_i);
        check_reset();
        reset_i = 1'b0;
        add_cases();
        subb_cases();
        muldiv_cases();
        da_cases();
        rotate_cases();
        port_cases();
        complete_run();
    end

endmodule
